// ---- logic/rtc_defs.svh ----
// offsets, field positions, reset values and timing counts of the rtc interrupt/rate block
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH

// register byte offsets
`define OFF_CTRL_A 8'h00
`define OFF_CTRL_B 8'h04
`define OFF_FLAGS 8'h08
`define OFF_ALARM 8'h0C
`define OFF_TIME 8'h10

// control a fields
`define A_RATE 3:0
`define A_OSC 6:4
`define A_UIP 7

// control b fields
`define B_SET 7
`define B_PIE 6
`define B_AIE 5
`define B_UIE 4
`define B_SQUARE_WAVE_ENABLE 3

// flag register fields
`define F_ANY 7
`define F_SRC 6:4
`define F_LOW 3:0

// byte lanes of the time and alarm words
`define TOD_BITS 23:0
`define BYTE_DONT_CARE 7:6

// reset values and field codes
`define RATE_RESET 4'h0
`define OSC_RESET 3'b010
`define OSC_RUN_CODE 3'b010
`define OSC_HOLD_CODE 2'b11
`define DONT_CARE_CODE 2'b11

// time base and divider chain
`define CLK_HZ 100000000
`define TB_HZ 32768
`define DIV_STAGES 15
`define PRE_UPDATE_US 244
`define US_PER_S 1000000
`define PRE_UPDATE_TICKS ((`PRE_UPDATE_US * `TB_HZ + `US_PER_S - 1) / `US_PER_S)

// divider taps for the rate codes that alias slower codes, and the offset of the rest
`define TAP_CODE1 6
`define TAP_CODE2 7
`define TAP_OFFSET 4'h2

// counter limits (binary)
`define SEC_MAX 8'h3B
`define MIN_MAX 8'h3B
`define HR_MAX 8'h17

`endif

// ---- logic/rtc_pkg.sv ----
// types shared by the rtc interrupt/rate block
package rtc_pkg;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    logic [7:0] hours;
    logic [7:0] minutes;
    logic [7:0] seconds;
  } tod_t;

  typedef struct packed {
    logic periodic;
    logic alarm;
    logic update;
  } flags_t;

  typedef enum logic [1:0] {
    OSC_STOP = 2'b00,
    OSC_RUN = 2'b01,
    OSC_HOLD = 2'b10
  } osc_mode_t;

endpackage : rtc_pkg

// ---- logic/rtc_irq_rate.sv ----
// rtc interrupt, periodic rate, square wave, oscillator control and update cycle
// Notes on behaviour
// - enable bit zero keeps source off irq
// - enabling a set flag raises irq at once
// - flags set on events regardless of enables
// - flag register read clears all flags
// - flags frozen during read, late events held
// - irq low while any flag&enable pair set
// - bit 7 reads one exactly while irq low
// - one rate field drives periodic and square
// - oscillator code 010 runs the chain
// - code 11x holds chain, others stop oscillator
// - selected tap on pin only when enabled
// - rate codes map to documented tap periods
// - update cycle every second, set bit ignored
// - set freezes user copy, internal copy advances
// - alarm when all three bytes match/don't-care
// - update-ended flag after every update
// - update flag high 244 us before transfer
// - update flag rises between periodic flag settings
// - set written high clears update-ended enable
// - reset clears periodic, alarm, update flags
// - flag bits 0 to 3 read zero
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "rtc_defs.svh"

module rtc_irq_rate #(
  parameter int unsigned CLK_HZ = `CLK_HZ,
  parameter int unsigned TB_HZ = `TB_HZ
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // apb slave
  input wire rtc_pkg::apb_req_t apb_req,
  output rtc_pkg::apb_rsp_t apb_rsp,
  // device pins
  output logic irq_n,
  output logic square_wave_out
);
  import rtc_pkg::*;

  localparam int unsigned DW = `DIV_STAGES;
  // update_in_progress rises at this divider count, PRE_UPDATE_TICKS ticks before the divider wraps
  localparam logic [DW-1:0] UIP_AT = DW'((1 << DW) - `PRE_UPDATE_TICKS);

  // 010 runs the chain; 11x runs the oscillator but holds the chain
  function automatic osc_mode_t osc_decode(input logic [2:0] f);
    if (f == `OSC_RUN_CODE) begin
      return OSC_RUN;
    end else if (f[2:1] == `OSC_HOLD_CODE) begin
      return OSC_HOLD;
    end
    return OSC_STOP;
  endfunction : osc_decode

  function automatic logic [7:0] wrap_inc(input logic [7:0] v, input logic [7:0] max);
    return (v >= max) ? 8'h00 : 8'(v + 8'h01);
  endfunction : wrap_inc

  // an alarm byte with its top two bits set matches any value
  function automatic logic byte_hit(input logic [7:0] a, input logic [7:0] t);
    return (a[`BYTE_DONT_CARE] == `DONT_CARE_CODE) || (a == t);
  endfunction : byte_hit

  // code n >= 3 picks stage n-2; codes 1 and 2 alias codes 8 and 9
  function automatic logic tap_of(input logic [3:0] rate, input logic [DW-1:0] cnt);
    logic t;
    t = 1'b0;
    case (rate)
      4'h0: t = 1'b0;
      4'h1: t = cnt[`TAP_CODE1];
      4'h2: t = cnt[`TAP_CODE2];
      default: t = cnt[4'(rate - `TAP_OFFSET)];
    endcase
    return t;
  endfunction : tap_of

  // ---------------- apb decode ----------------
  logic setup;
  logic done;
  logic wr;
  logic rd;
  // unmapped offsets answer with pslverr and read as zero
  logic hit;
  assign setup = apb_req.psel & ~apb_req.penable;
  assign done = apb_req.psel & apb_req.penable & apb_rsp.pready;
  assign wr = done & apb_req.pwrite;
  assign rd = done & ~apb_req.pwrite;

  always_comb begin
    case (apb_req.paddr)
      `OFF_CTRL_A, `OFF_CTRL_B, `OFF_FLAGS, `OFF_ALARM, `OFF_TIME: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // ---------------- control registers ----------------
  logic [3:0] rate_ff, nxt_rate;
  logic [2:0] osc_ff, nxt_osc;
  logic set_ff, nxt_set;
  logic pie_ff, nxt_pie;
  logic aie_ff, nxt_aie;
  logic uie_ff, nxt_uie;
  logic square_wave_enable_ff, nxt_square_wave_enable;

  always_comb begin
    nxt_rate = rate_ff;
    nxt_osc = osc_ff;
    nxt_set = set_ff;
    nxt_pie = pie_ff;
    nxt_aie = aie_ff;
    nxt_uie = uie_ff;
    nxt_square_wave_enable = square_wave_enable_ff;
    if (wr && apb_req.paddr == `OFF_CTRL_A) begin
      nxt_rate = apb_req.pwdata[`A_RATE];
      nxt_osc = apb_req.pwdata[`A_OSC];
    end
    if (wr && apb_req.paddr == `OFF_CTRL_B) begin
      nxt_set = apb_req.pwdata[`B_SET];
      nxt_pie = apb_req.pwdata[`B_PIE];
      nxt_aie = apb_req.pwdata[`B_AIE];
      nxt_square_wave_enable = apb_req.pwdata[`B_SQUARE_WAVE_ENABLE];
      // a set write wins over a simultaneous update-ended enable write
      nxt_uie = apb_req.pwdata[`B_UIE] & ~apb_req.pwdata[`B_SET];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rate_ff <= `RATE_RESET;
      osc_ff <= `OSC_RESET;
      set_ff <= 1'b0;
      pie_ff <= 1'b0;
      aie_ff <= 1'b0;
      uie_ff <= 1'b0;
      square_wave_enable_ff <= 1'b0;
    end else begin
      rate_ff <= nxt_rate;
      osc_ff <= nxt_osc;
      set_ff <= nxt_set;
      pie_ff <= nxt_pie;
      aie_ff <= nxt_aie;
      uie_ff <= nxt_uie;
      square_wave_enable_ff <= nxt_square_wave_enable;
    end
  end

  // ---------------- time base and divider chain ----------------
  // fractional accumulator: no integer ratio exists between 100 MHz and 32.768 kHz,
  // so ticks jitter by one clock but the long-run rate is exact
  logic [31:0] acc_ff, nxt_acc;
  logic [32:0] acc_sum;
  logic [DW-1:0] div_ff, nxt_div;
  logic uip_ff, nxt_uip;
  logic tap_prev_ff, nxt_tap_prev;
  logic sqw_ff, nxt_sqw;
  logic tick;
  logic update;
  logic tap;
  logic pf_ev;
  osc_mode_t mode;

  always_comb begin
    mode = osc_decode(osc_ff);
    acc_sum = {1'b0, acc_ff} + 33'(TB_HZ);
    tick = 1'b0;
    nxt_acc = acc_ff;
    if (mode != OSC_STOP) begin
      if (acc_sum >= 33'(CLK_HZ)) begin
        tick = 1'b1;
        nxt_acc = 32'(acc_sum - 33'(CLK_HZ));
      end else begin
        nxt_acc = acc_sum[31:0];
      end
    end
    nxt_div = div_ff;
    nxt_uip = uip_ff;
    update = 1'b0;
    // a stopped or held chain restarts from zero, so the first second is whole
    if (mode != OSC_RUN) begin
      nxt_div = '0;
      nxt_uip = 1'b0;
    end else if (tick) begin
      nxt_div = DW'(div_ff + 1'b1);
      if (div_ff == DW'(UIP_AT - 1'b1)) begin
        nxt_uip = 1'b1;
      end
      if (&div_ff) begin
        update = 1'b1;
        nxt_uip = 1'b0;
      end
    end
    tap = tap_of(rate_ff, div_ff);
    nxt_tap_prev = tap;
    // rising edge of the tap; a rate change can add one spurious event
    pf_ev = tap & ~tap_prev_ff;
    nxt_sqw = tap & square_wave_enable_ff;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc_ff <= '0;
      div_ff <= '0;
      uip_ff <= 1'b0;
      tap_prev_ff <= 1'b0;
      sqw_ff <= 1'b0;
    end else begin
      acc_ff <= nxt_acc;
      div_ff <= nxt_div;
      uip_ff <= nxt_uip;
      tap_prev_ff <= nxt_tap_prev;
      sqw_ff <= nxt_sqw;
    end
  end

  // ---------------- time of day and alarm ----------------
  tod_t tod_int_ff, nxt_tod_int;
  tod_t tod_usr_ff, nxt_tod_usr;
  tod_t alarm_ff, nxt_alarm;
  logic al_ev;

  always_comb begin
    nxt_tod_int = tod_int_ff;
    nxt_tod_usr = tod_usr_ff;
    nxt_alarm = alarm_ff;
    al_ev = 1'b0;
    if (update) begin
      nxt_tod_int.seconds = wrap_inc(tod_int_ff.seconds, `SEC_MAX);
      if (tod_int_ff.seconds >= `SEC_MAX) begin
        nxt_tod_int.minutes = wrap_inc(tod_int_ff.minutes, `MIN_MAX);
        if (tod_int_ff.minutes >= `MIN_MAX) begin
          nxt_tod_int.hours = wrap_inc(tod_int_ff.hours, `HR_MAX);
        end
      end
      if (!set_ff) begin
        nxt_tod_usr = nxt_tod_int;
      end
      al_ev = byte_hit(alarm_ff.seconds, nxt_tod_int.seconds)
            & byte_hit(alarm_ff.minutes, nxt_tod_int.minutes)
            & byte_hit(alarm_ff.hours, nxt_tod_int.hours);
    end
    // a host write loads both copies and wins over a same-cycle update
    if (wr && apb_req.paddr == `OFF_TIME) begin
      nxt_tod_int = apb_req.pwdata[`TOD_BITS];
      nxt_tod_usr = apb_req.pwdata[`TOD_BITS];
    end
    if (wr && apb_req.paddr == `OFF_ALARM) begin
      nxt_alarm = apb_req.pwdata[`TOD_BITS];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tod_int_ff <= '0;
      tod_usr_ff <= '0;
      alarm_ff <= '0;
    end else begin
      tod_int_ff <= nxt_tod_int;
      tod_usr_ff <= nxt_tod_usr;
      alarm_ff <= nxt_alarm;
    end
  end

  // ---------------- flags and interrupt request ----------------
  // the flag snapshot is taken into prdata at the setup edge; from then until the
  // access edge new events go to a pending copy and land after the clear
  flags_t flags_ff, nxt_flags;
  flags_t pend_ff, nxt_pend;
  flags_t ev;
  logic busy_ff, nxt_busy;
  logic irq_n_ff, nxt_irq_n;
  logic flag_setup;
  logic irq_on;

  always_comb begin
    ev = '{periodic: pf_ev, alarm: al_ev, update: update};
    flag_setup = setup & ~apb_req.pwrite & (apb_req.paddr == `OFF_FLAGS);
    nxt_flags = flags_ff;
    nxt_pend = pend_ff;
    nxt_busy = busy_ff;
    // set wins: an event in the clearing cycle lands after the clear
    if (rd && busy_ff) begin
      nxt_flags = pend_ff | ev;
      nxt_pend = '0;
      nxt_busy = 1'b0;
    end else if (busy_ff || flag_setup) begin
      nxt_pend = pend_ff | ev;
      nxt_busy = 1'b1;
    end else begin
      nxt_flags = flags_ff | ev;
    end
    // next-state terms, so irq_n follows an enable write at the same edge as the enable register
    irq_on = (nxt_flags.periodic & nxt_pie)
           | (nxt_flags.alarm & nxt_aie)
           | (nxt_flags.update & nxt_uie);
    nxt_irq_n = ~irq_on;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flags_ff <= '0;
      pend_ff <= '0;
      busy_ff <= 1'b0;
      irq_n_ff <= 1'b1;
    end else begin
      flags_ff <= nxt_flags;
      pend_ff <= nxt_pend;
      busy_ff <= nxt_busy;
      irq_n_ff <= nxt_irq_n;
    end
  end

  // ---------------- apb response ----------------
  // no wait state: read data is registered at the setup edge, so prdata is a flop
  apb_rsp_t rsp_ff, nxt_rsp;
  logic [31:0] rmux;

  always_comb begin
    rmux = '0;
    case (apb_req.paddr)
      `OFF_CTRL_A: begin
        rmux[`A_RATE] = rate_ff;
        rmux[`A_OSC] = osc_ff;
        rmux[`A_UIP] = uip_ff;
      end
      `OFF_CTRL_B: begin
        rmux[`B_SET] = set_ff;
        rmux[`B_PIE] = pie_ff;
        rmux[`B_AIE] = aie_ff;
        rmux[`B_UIE] = uie_ff;
        rmux[`B_SQUARE_WAVE_ENABLE] = square_wave_enable_ff;
      end
      `OFF_FLAGS: begin
        rmux[`F_ANY] = ~irq_n_ff;
        rmux[`F_SRC] = flags_ff;
        rmux[`F_LOW] = 4'h0;
      end
      `OFF_ALARM: begin
        rmux[`TOD_BITS] = alarm_ff;
      end
      `OFF_TIME: begin
        rmux[`TOD_BITS] = tod_usr_ff;
      end
      default: begin
        rmux = '0;
      end
    endcase
    nxt_rsp = rsp_ff;
    nxt_rsp.pready = setup;
    if (setup) begin
      nxt_rsp.pslverr = ~hit;
      nxt_rsp.prdata = apb_req.pwrite ? 32'h0000_0000 : rmux;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff <= nxt_rsp;
    end
  end

  assign apb_rsp = rsp_ff;
  assign irq_n = irq_n_ff;
  assign square_wave_out = sqw_ff;

endmodule : rtc_irq_rate

// ---- sim/rtc_irq_rate_props.sv ----
// port checker of the rtc interrupt/rate block
`timescale 1ns/1ps
`include "rtc_defs.svh"
module rtc_irq_rate_props import rtc_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register bus
  input wire rtc_pkg::apb_req_t apb_req,
  input wire rtc_pkg::apb_rsp_t apb_rsp,
  // pins
  input wire logic irq_n,
  input wire logic square_wave_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic setup, acc, hi;
  // enables as last written: periodic, alarm, update, square
  logic [3:0] en_ff;
  logic [3:0] nxt_en;
  assign setup = apb_req.psel && !apb_req.penable;
  assign acc = apb_req.psel && apb_req.penable && apb_rsp.pready;
  // hi marks an unmapped offset, above or between the registers
  assign hi = !(apb_req.paddr inside {`OFF_CTRL_A, `OFF_CTRL_B, `OFF_FLAGS,
    `OFF_ALARM, `OFF_TIME});
  always_comb begin
    nxt_en = en_ff;
    if (acc && apb_req.pwrite && apb_req.paddr == `OFF_CTRL_B) begin
      nxt_en = apb_req.pwdata[6:3];
      nxt_en[1] = nxt_en[1] && !apb_req.pwdata[`B_SET];
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) en_ff <= 4'h0;
    else en_ff <= nxt_en;
  end
  sequence s_answer; apb_rsp.pready ##1 !apb_rsp.pready; endsequence
  sequence s_flag_rd; acc && !apb_req.pwrite && apb_req.paddr == `OFF_FLAGS; endsequence
  property p_ready; setup |=> s_answer; endproperty
  property p_hold; !setup |=> $stable(apb_rsp.prdata); endproperty
  property p_low; s_flag_rd |-> apb_rsp.prdata[`F_LOW] == 4'h0; endproperty
  property p_any; s_flag_rd |-> apb_rsp.prdata[`F_ANY] == !$past(irq_n); endproperty
  property p_refused; acc && hi |-> apb_rsp.pslverr && apb_rsp.prdata == 32'h0; endproperty
  property p_mapped; acc && !hi |-> !apb_rsp.pslverr; endproperty
  // a flag left set must not reach the pin once all three irq enables are gone
  property p_masked; en_ff[3:1] == 3'h0 |-> irq_n; endproperty
  property p_sqw_off; !en_ff[0] |=> !square_wave_out; endproperty
  a_ready: assert property (p_ready) else $error("pready wrong");
  a_hold: assert property (p_hold) else $error("prdata moved");
  a_low: assert property (p_low) else $error("low flag bits set");
  a_any: assert property (p_any) else $error("summary bit off pin");
  a_refused: assert property (p_refused) else $error("bad address taken");
  a_mapped: assert property (p_mapped) else $error("good address refused");
  a_masked: assert property (p_masked) else $error("irq while masked");
  a_sqw_off: assert property (p_sqw_off) else $error("square wave while off");
endmodule : rtc_irq_rate_props

bind rtc_irq_rate rtc_irq_rate_props u_props (.clk(clk), .resetn(resetn), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .irq_n(irq_n), .square_wave_out(square_wave_out));

// ---- sim/rtc_host.sv ----
// register-bus host model facing the rtc block
`timescale 1ns/1ps
module rtc_host import rtc_pkg::*; (
  // clock
  input wire logic clk,
  // register bus
  output rtc_pkg::apb_req_t apb_req,
  input wire rtc_pkg::apb_rsp_t apb_rsp
);
  initial apb_req = '0;
  // two-cycle transfers keep any read burst well inside the safe windows
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic err);
    @(posedge clk);
    apb_req <= '{1'h1, 1'h0, w, a, d};
    @(posedge clk);
    apb_req.penable <= 1'h1;
    do @(posedge clk); while (apb_rsp.pready !== 1'h1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
  endtask : xfer
endmodule : rtc_host

// ---- sim/rtc_irq_rate_bench.sv ----
// self-checking bench of the rtc interrupt/rate block
`timescale 1ns/1ps
`include "rtc_defs.svh"
module rtc_irq_rate_bench;
  import rtc_pkg::*;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} row_t;
  row_t rows [9] = '{
    '{1'h0, `OFF_CTRL_A, 32'h0, 32'h20, 1'h0},
    '{1'h0, `OFF_CTRL_B, 32'h0, 32'h0, 1'h0},
    '{1'h1, `OFF_FLAGS, 32'hFF, 32'h0, 1'h0},
    '{1'h0, `OFF_FLAGS, 32'h0, 32'h0, 1'h0},
    '{1'h1, `OFF_ALARM, 32'hC0C0C0, 32'h0, 1'h0},
    '{1'h0, `OFF_ALARM, 32'h0, 32'hC0C0C0, 1'h0},
    '{1'h1, `OFF_TIME, 32'h173B3A, 32'h0, 1'h0},
    '{1'h0, `OFF_TIME, 32'h0, 32'h173B3A, 1'h0},
    '{1'h0, 8'h40, 32'h0, 32'h0, 1'h1}
  };
  logic clk = 1'h0;
  logic resetn = 1'h0;
  apb_req_t apb_req;
  apb_rsp_t apb_rsp;
  logic irq_n;
  logic square_wave_out;
  logic [31:0] rd;
  logic err;
  int miscompares = 0;
  int n_compared = 0;
  time t0;
  always #5 clk = ~clk;
  // time base at half the clock: one tick every two cycles
  rtc_irq_rate #(.CLK_HZ(100), .TB_HZ(50)) uut (.clk(clk), .resetn(resetn), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .irq_n(irq_n), .square_wave_out(square_wave_out));
  rtc_host host (.clk(clk), .apb_req(apb_req), .apb_rsp(apb_rsp));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'h1, a, d, rd, err);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    host.xfer(1'h0, a, 32'h0, rd, err);
    chk(rd, x);
  endtask : rdc
  task automatic irq_is(input logic x);
    repeat (2) @(posedge clk);
    chk({31'h0, irq_n}, {31'h0, x});
  endtask : irq_is
  task automatic stop_test;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  initial begin
    repeat (95000) @(posedge clk);
    miscompares++;
    stop_test;
  end
  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'h1;
    foreach (rows[i]) begin
      host.xfer(rows[i].w, rows[i].a, rows[i].d, rd, err);
      if (!rows[i].w) chk(rd, rows[i].x);
      chk({31'h0, err}, {31'h0, rows[i].e});
    end
    wr(`OFF_CTRL_B, 32'h8);
    for (int c = 1; c < 11; c++) begin
      wr(`OFF_CTRL_A, 32'h20 | c);
      repeat (2) @(posedge square_wave_out);
      t0 = $time;
      @(posedge square_wave_out);
      chk(32'(($time - t0) / 20),
        c < 3 ? 32'h40 << c : 32'h1 << (c - 1));
    end
    wr(`OFF_CTRL_B, 32'h0);
    wr(`OFF_CTRL_A, 32'h23);
    repeat (20) @(posedge clk);
    wr(`OFF_CTRL_A, 32'h20);
    irq_is(1'h1);
    wr(`OFF_CTRL_B, 32'h40);
    irq_is(1'h0);
    rdc(`OFF_FLAGS, 32'hC0);
    irq_is(1'h1);
    rdc(`OFF_FLAGS, 32'h0);
    wr(`OFF_CTRL_B, 32'h0);
    for (int o = 0; o < 8; o++) begin
      wr(`OFF_CTRL_A, 32'(o * 16 + 3));
      host.xfer(1'h0, `OFF_FLAGS, 32'h0, rd, err);
      repeat (20) @(posedge clk);
      host.xfer(1'h0, `OFF_FLAGS, 32'h0, rd, err);
      chk(rd & 32'h40, o == 2 ? 32'h40 : 32'h0);
    end
    wr(`OFF_CTRL_B, 32'h90);
    rdc(`OFF_CTRL_B, 32'h80);
    wr(`OFF_TIME, 32'h0);
    host.xfer(1'h0, `OFF_FLAGS, 32'h0, rd, err);
    // only the seconds byte is live, so a match needs the advanced time
    wr(`OFF_ALARM, 32'hC0C001);
    wr(`OFF_CTRL_B, 32'h10);
    wr(`OFF_CTRL_A, 32'h20);
    do host.xfer(1'h0, `OFF_CTRL_A, 32'h0, rd, err); while (rd[7] !== 1'h1);
    t0 = $time;
    while (irq_n !== 1'h0) @(posedge clk);
    chk(32'(($time - t0) / 10 inside {[10:20]}), 32'h1);
    rdc(`OFF_FLAGS, 32'hB0);
    rdc(`OFF_TIME, 32'h1);
    wr(`OFF_CTRL_B, 32'h78);
    wr(`OFF_CTRL_A, 32'h23);
    repeat (20) @(posedge clk);
    irq_is(1'h0);
    resetn <= 1'h0;
    irq_is(1'h1);
    resetn <= 1'h1;
    rdc(`OFF_FLAGS, 32'h0);
    rdc(`OFF_CTRL_B, 32'h0);
    stop_test;
  end
endmodule : rtc_irq_rate_bench
